// ### rtl/pmt_cfg.svh
/*
  Register offsets, field positions, reset values and timing counts of the
  period match timer. Included by the design modules and the testbench.
*/
`ifndef PMT_CFG_SVH
`define PMT_CFG_SVH

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define OFS_COUNT       12'h000
`define OFS_PERIOD      12'h004
`define OFS_CONTROL     12'h008
`define OFS_IRQ_FLAG    12'h00c
`define OFS_IRQ_ENABLE  12'h010
`define OFS_SLEEP       12'h014

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define CTL_POST_HI     6
`define CTL_POST_LO     3
`define CTL_RUN_BIT     2
`define CTL_PRE_HI      1
`define CTL_PRE_LO      0
`define CTL_WR_MASK     8'h7f

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_COUNT       8'h00
`define RST_PERIOD      8'hff
`define RST_CONTROL     8'h00

// ----------------------------------------------------------------
// Timing: instruction clock is a quarter of the system clock
// ----------------------------------------------------------------
`define INSN_DIV        4
`define PRE_DIV_1       6'h00
`define PRE_DIV_4       6'h03
`define PRE_DIV_16      6'h0f
`define PRE_DIV_64      6'h3f

`endif

// ### rtl/pmt_pkg.sv
/*
  Types shared by the period match timer modules.
  Uses no macros from pmt_cfg.svh.
*/
package pmt_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [1:0] pre_sel_t;
  typedef logic [3:0] post_sel_t;
  typedef enum logic [1:0] {
    PH_IDLE  = 2'b00,
    PH_WRITE = 2'b01,
    PH_READ  = 2'b10
  } bus_phase_t;
endpackage

// ### rtl/pmt_tick_gen.sv
/*
  Instruction clock and prescaler: emits one tick per 1, 4, 16 or 64 counted instruction edges.
  Assumes a single system clock and a synchronous clear from the owner.
*/
`include "pmt_cfg.svh"

module pmt_tick_gen (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // Control
  input  wire logic              run,
  input  wire logic              clear,
  input  wire pmt_pkg::pre_sel_t pre_sel,
  // Output
  output logic                   tick
);
  import pmt_pkg::*;

  logic [1:0] insn_r;
  logic [5:0] pre_r;
  logic [5:0] pre_lim;
  logic       insn_edge;

  // ----------------------------------------------------------------
  // Prescale limit decode
  // ----------------------------------------------------------------
  always_comb begin
    case (pre_sel)
      2'b00:   pre_lim = `PRE_DIV_1;
      2'b01:   pre_lim = `PRE_DIV_4;
      2'b10:   pre_lim = `PRE_DIV_16;
      default: pre_lim = `PRE_DIV_64;
    endcase
  end

  // Instruction clock keeps running; the scaler alone is cleared
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      insn_r <= 2'h0;
    end else begin
      insn_r <= insn_r + 2'h1;
    end
  end

  assign insn_edge = (insn_r == 2'(`INSN_DIV - 1));

  always_ff @(posedge clk_sys) begin
    if (rst || clear) begin
      pre_r <= 6'h00;
    end else if (run && insn_edge) begin
      pre_r <= (pre_r >= pre_lim) ? 6'h00 : pre_r + 6'h01;
    end
  end

  assign tick = run && insn_edge && (pre_r >= pre_lim);

endmodule

// ### rtl/period_match_timer8.sv
/*
  Period match timer: 8-bit count, period compare, prescaler, postscaler,
  match flag with interrupt, AHB-Lite register slave.
  Assumes one AHB-Lite master with single word transfers, and a sleep
  level from the same clock domain.
*/
// The placing of the registers and the AHB-Lite register port are this design's own decisions.
//
// Contract
// - Timer clock is the instruction clock, a quarter of system clock.
// - Count starts at zero and increments on each prescaled tick.
// - Prescale codes divide by 1, 4, 16 and 64.
// - Count is compared with period every tick; equality is match.
// - On match the count returns to zero next tick.
// - Each match advances a 4-bit postscaler that sets the match flag.
// - Postscale ratio equals field value plus one.
// - Flag raises interrupt only while enabled; flag sets regardless.
// - Count and period are readable and writable at any time.
// - Reset clears count and loads period with all ones.
// - Count write, control write and reset clear both scalers.
// - Control write leaves the count unchanged.
// - Run bit starts and stops the timer; resets to zero.
// - Match pulse is synchronous with the system clock.
// - In sleep the timer halts and registers keep their values.
// - Control bit 7 ignores writes and reads zero.
// - Control holds postscale 6:3, run bit 2, prescale 1:0.
`include "pmt_cfg.svh"

module period_match_timer8 (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Power state
  input  wire logic        sleep,
  // Timer outputs
  output logic             period_match_pulse,
  output logic             irq
);
  import pmt_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  byte_t      timer_count_r;
  byte_t      timer_period_r;
  byte_t      scaler_control_r;
  logic       match_flag_r;
  logic       match_irq_enable_r;
  logic       sleep_r;
  post_sel_t  post_r;
  bus_phase_t phase_r;
  logic [11:0] addr_r;

  logic       run;
  logic       tick;
  logic       match;
  logic       post_done;
  logic       scaler_clear;
  logic       wr_count;
  logic       wr_period;
  logic       wr_control;
  logic       wr_flag;
  logic       wr_enable;
  logic       wr_sleep;
  logic       addr_ok;
  byte_t      wbyte;
  logic       match_flag_nxt;
  logic       match_irq_enable_nxt;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction

  // ----------------------------------------------------------------
  // AHB-Lite address and data phase
  // ----------------------------------------------------------------
  assign addr_ok = hsel && hready && htrans[1];

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      phase_r <= PH_IDLE;
      addr_r  <= 12'h000;
    end else if (hready) begin
      phase_r <= !addr_ok ? PH_IDLE : (hwrite ? PH_WRITE : PH_READ);
      addr_r  <= haddr;
    end
  end

  assign wbyte      = hwdata[7:0];
  assign wr_count   = (phase_r == PH_WRITE) && hit(addr_r, `OFS_COUNT);
  assign wr_period  = (phase_r == PH_WRITE) && hit(addr_r, `OFS_PERIOD);
  assign wr_control = (phase_r == PH_WRITE) && hit(addr_r, `OFS_CONTROL);
  assign wr_flag    = (phase_r == PH_WRITE) && hit(addr_r, `OFS_IRQ_FLAG);
  assign wr_enable  = (phase_r == PH_WRITE) && hit(addr_r, `OFS_IRQ_ENABLE);
  assign wr_sleep   = (phase_r == PH_WRITE) && hit(addr_r, `OFS_SLEEP);

  // Zero wait states; unmapped reads return zero, writes are dropped
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
      if (addr_ok && !hwrite) begin
        if (hit(haddr, `OFS_COUNT)) begin
          hrdata <= {24'h000000, timer_count_r};
        end else if (hit(haddr, `OFS_PERIOD)) begin
          hrdata <= {24'h000000, timer_period_r};
        end else if (hit(haddr, `OFS_CONTROL)) begin
          hrdata <= {24'h000000, 1'b0, scaler_control_r[6:0]};
        end else if (hit(haddr, `OFS_IRQ_FLAG)) begin
          hrdata <= {31'h00000000, match_flag_r};
        end else if (hit(haddr, `OFS_IRQ_ENABLE)) begin
          hrdata <= {31'h00000000, match_irq_enable_r};
        end else if (hit(haddr, `OFS_SLEEP)) begin
          hrdata <= {31'h00000000, sleep_r};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Control and power registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      scaler_control_r <= `RST_CONTROL;
    end else if (wr_control) begin
      scaler_control_r <= wbyte & `CTL_WR_MASK;
    end
  end

  // Software sleep request ORed with the core's sleep level
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sleep_r <= 1'b0;
    end else if (wr_sleep) begin
      sleep_r <= wbyte[0];
    end
  end

  assign run = scaler_control_r[`CTL_RUN_BIT] && !sleep && !sleep_r;
  assign scaler_clear = wr_count || wr_control;

  pmt_tick_gen u_tick (
    .clk_sys (clk_sys),
    .rst     (rst),
    .run     (run),
    .clear   (scaler_clear),
    .pre_sel (scaler_control_r[`CTL_PRE_HI:`CTL_PRE_LO]),
    .tick    (tick)
  );

  // ----------------------------------------------------------------
  // Count, period and compare
  // ----------------------------------------------------------------
  assign match = tick && (timer_count_r == timer_period_r);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      timer_count_r <= `RST_COUNT;
    end else if (wr_count) begin
      timer_count_r <= wbyte;
    end else if (match) begin
      timer_count_r <= 8'h00;
    end else if (tick) begin
      timer_count_r <= timer_count_r + 8'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      timer_period_r <= `RST_PERIOD;
    end else if (wr_period) begin
      timer_period_r <= wbyte;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      period_match_pulse <= 1'b0;
    end else begin
      period_match_pulse <= match;
    end
  end

  // ----------------------------------------------------------------
  // Postscaler and match flag
  // ----------------------------------------------------------------
  assign post_done = match && (post_r == scaler_control_r[`CTL_POST_HI:`CTL_POST_LO]);

  always_ff @(posedge clk_sys) begin
    if (rst || scaler_clear) begin
      post_r <= 4'h0;
    end else if (post_done) begin
      post_r <= 4'h0;
    end else if (match) begin
      post_r <= post_r + 4'h1;
    end
  end

  // Set beats a write-one clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      match_flag_r <= 1'b0;
    end else if (post_done) begin
      match_flag_r <= 1'b1;
    end else if (wr_flag && wbyte[0]) begin
      match_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      match_irq_enable_r <= 1'b0;
    end else if (wr_enable) begin
      match_irq_enable_r <= wbyte[0];
    end
  end

  // Next values, so irq drops in the same cycle as a clear or mask
  assign match_flag_nxt       = post_done || (match_flag_r && !(wr_flag && wbyte[0]));
  assign match_irq_enable_nxt = wr_enable ? wbyte[0] : match_irq_enable_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= match_flag_nxt && match_irq_enable_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_match_clears;
    @(posedge clk_sys) disable iff (rst)
      (match && !wr_count) |=> (timer_count_r == 8'h00);
  endproperty
  a_match_clears: assert property (p_match_clears) else $error("count not cleared");

  property p_tick_incr;
    @(posedge clk_sys) disable iff (rst)
      (tick && !match && !wr_count) |=> (timer_count_r == $past(timer_count_r) + 8'h01);
  endproperty
  a_tick_incr: assert property (p_tick_incr) else $error("count did not step");

  property p_pulse;
    @(posedge clk_sys) disable iff (rst)
      match |=> period_match_pulse;
  endproperty
  a_pulse: assert property (p_pulse) else $error("match pulse missing");

  property p_stopped_hold;
    @(posedge clk_sys) disable iff (rst)
      (!run && !wr_count) |=> (timer_count_r == $past(timer_count_r)) && !period_match_pulse;
  endproperty
  a_stopped_hold: assert property (p_stopped_hold) else $error("count moved while stopped");

  property p_sleep_hold;
    @(posedge clk_sys) disable iff (rst)
      (sleep && !wr_count && !wr_period) |=> $stable(timer_count_r) && $stable(timer_period_r);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("register changed in sleep");

  property p_ctl_keeps_count;
    @(posedge clk_sys) disable iff (rst)
      (wr_control && !tick) |=> $stable(timer_count_r);
  endproperty
  a_ctl_keeps_count: assert property (p_ctl_keeps_count) else $error("control write hit count");

  property p_scaler_clear;
    @(posedge clk_sys) disable iff (rst)
      scaler_clear |=> (post_r == 4'h0);
  endproperty
  a_scaler_clear: assert property (p_scaler_clear) else $error("postscaler not cleared");

  property p_flag_set;
    @(posedge clk_sys) disable iff (rst)
      post_done |=> match_flag_r;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set");

  property p_irq_gate;
    @(posedge clk_sys) disable iff (rst)
      (match_flag_r && match_irq_enable_r) |-> irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq missing");

  property p_irq_masked;
    @(posedge clk_sys) disable iff (rst)
      !match_irq_enable_r |-> !irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("irq while masked");

  property p_bit7_zero;
    @(posedge clk_sys) disable iff (rst)
      1'b1 |-> !scaler_control_r[7];
  endproperty
  a_bit7_zero: assert property (p_bit7_zero) else $error("control bit 7 set");

  property p_irq_no_flag;
    @(posedge clk_sys) disable iff (rst)
      !match_flag_r |-> !irq;
  endproperty
  a_irq_no_flag: assert property (p_irq_no_flag) else $error("irq without flag");

  property p_pulse_only;
    @(posedge clk_sys) disable iff (rst)
      !match |=> !period_match_pulse;
  endproperty
  a_pulse_only: assert property (p_pulse_only) else $error("pulse without match");

  property p_count_idle;
    @(posedge clk_sys) disable iff (rst)
      (!tick && !wr_count) |=> $stable(timer_count_r);
  endproperty
  a_count_idle: assert property (p_count_idle) else $error("count moved without tick");

  property p_period_hold;
    @(posedge clk_sys) disable iff (rst)
      !wr_period |=> $stable(timer_period_r);
  endproperty
  a_period_hold: assert property (p_period_hold) else $error("period changed unwritten");

  property p_post_step;
    @(posedge clk_sys) disable iff (rst)
      (match && !post_done && !scaler_clear) |=> (post_r == $past(post_r) + 4'h1);
  endproperty
  a_post_step: assert property (p_post_step) else $error("postscaler did not step");

  c_match:    cover property (@(posedge clk_sys) disable iff (rst) match);
  c_flag:     cover property (@(posedge clk_sys) disable iff (rst) post_done && post_r != 4'h0);
  c_irq:      cover property (@(posedge clk_sys) disable iff (rst) $rose(irq));
  c_sleeping: cover property (@(posedge clk_sys) disable iff (rst)
                scaler_control_r[`CTL_RUN_BIT] && sleep);

endmodule

// ### testbench/test_period_match_timer8.sv
/*
  Self-checking bench for the period match timer.
  Assumes the design's AHB-Lite slave with hready tied to hreadyout.
*/
`include "pmt_cfg.svh"

module test_period_match_timer8;
  timeunit 1ns;
  timeprecision 1ps;
  import pmt_pkg::*;

  // ----------------------------------------------------------------
  // Signals and design
  // ----------------------------------------------------------------
  logic        clk_sys = 1'b0;
  logic        rst     = 1'b1;
  logic        hsel    = 1'b0;
  logic [11:0] haddr   = 12'h000;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [2:0]  hsize   = 3'h2;
  logic [31:0] hwdata  = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        sleep   = 1'b0;
  logic        period_match_pulse;
  logic        irq;
  logic [31:0] rd;
  int          bad_count = 0;
  int          n_tests   = 0;
  int          cyc       = 0;

  period_match_timer8 dut (
    .clk_sys           (clk_sys),
    .rst               (rst),
    .hsel              (hsel),
    .haddr             (haddr),
    .htrans            (htrans),
    .hwrite            (hwrite),
    .hsize             (hsize),
    .hwdata            (hwdata),
    .hready            (hreadyout),
    .hrdata            (hrdata),
    .hreadyout         (hreadyout),
    .hresp             (hresp),
    .sleep             (sleep),
    .period_match_pulse(period_match_pulse),
    .irq               (irq)
  );

  always #10 clk_sys = ~clk_sys;

  // Ceiling well above the longest prescale gap measurement
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  function automatic logic [31:0] ctl(input logic [3:0] post, input logic run,
                                      input logic [1:0] pre);
    return {25'h0, post, run, pre};
  endfunction

  task automatic wait_pulse();
    do @(posedge clk_sys); while (period_match_pulse !== 1'b1);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rdchk("count", `OFS_COUNT, 32'h00);
    rdchk("period", `OFS_PERIOD, 32'hff);
    rdchk("control", `OFS_CONTROL, 32'h00);
    rdchk("flag", `OFS_IRQ_FLAG, 32'h00);
    chk("irq", 32'h0, {31'h0, irq});
  endtask

  task automatic t_regs();
    wr(`OFS_PERIOD, 32'ha5);
    rdchk("period", `OFS_PERIOD, 32'ha5);
    wr(`OFS_COUNT, 32'h3c);
    rdchk("count", `OFS_COUNT, 32'h3c);
    wr(`OFS_CONTROL, 32'hff);
    rdchk("control", `OFS_CONTROL, 32'h7f);
    wr(`OFS_CONTROL, 32'h00);
    wr(12'h020, 32'hff);
    rdchk("unmapped", 12'h020, 32'h0);
  endtask

  task automatic t_rate();
    int n;
    wr(`OFS_PERIOD, 32'h03);
    wr(`OFS_COUNT, 32'h00);
    for (int p = 0; p < 4; p++) begin
      wr(`OFS_CONTROL, ctl(4'h0, 1'b1, p[1:0]));
      // First pulse may still belong to the old rate
      wait_pulse();
      wait_pulse();
      n = 0;
      do begin
        @(posedge clk_sys);
        n++;
      end while (period_match_pulse !== 1'b1);
      chk("match gap", 32'd16 << (2 * p), n);
    end
    wr(`OFS_CONTROL, 32'h00);
  endtask

  task automatic t_hold();
    logic [31:0] v;
    wr(`OFS_PERIOD, 32'hff);
    wr(`OFS_CONTROL, ctl(4'h0, 1'b1, 2'b00));
    sleep <= 1'b1;
    wr(`OFS_COUNT, 32'h0a);
    repeat (100) @(posedge clk_sys);
    rdchk("sleep count", `OFS_COUNT, 32'h0a);
    rdchk("sleep period", `OFS_PERIOD, 32'hff);
    sleep <= 1'b0;
    repeat (40) @(posedge clk_sys);
    bus(1'b0, `OFS_COUNT, 32'h0);
    chk("counting", 32'h1, {31'h0, rd[7:0] > 8'h0a});
    wr(`OFS_SLEEP, 32'h1);
    rdchk("soft sleep", `OFS_SLEEP, 32'h1);
    bus(1'b0, `OFS_COUNT, 32'h0);
    v = rd;
    repeat (100) @(posedge clk_sys);
    rdchk("soft sleep count", `OFS_COUNT, v);
    wr(`OFS_SLEEP, 32'h0);
    wr(`OFS_CONTROL, ctl(4'h0, 1'b0, 2'b00));
    bus(1'b0, `OFS_COUNT, 32'h0);
    v = rd;
    repeat (100) @(posedge clk_sys);
    rdchk("stopped count", `OFS_COUNT, v);
  endtask

  task automatic t_scaler_clear();
    wr(`OFS_COUNT, 32'h05);
    wr(`OFS_CONTROL, ctl(4'h0, 1'b1, 2'b11));
    // Rewrites closer than one prescaled count keep the count still
    repeat (4) begin
      repeat (150) @(posedge clk_sys);
      wr(`OFS_CONTROL, ctl(4'h0, 1'b1, 2'b11));
    end
    rdchk("ctl write count", `OFS_COUNT, 32'h05);
    repeat (4) begin
      repeat (150) @(posedge clk_sys);
      wr(`OFS_COUNT, 32'h05);
    end
    rdchk("cnt write count", `OFS_COUNT, 32'h05);
    repeat (300) @(posedge clk_sys);
    rdchk("one step", `OFS_COUNT, 32'h06);
    wr(`OFS_CONTROL, 32'h00);
  endtask

  task automatic t_post();
    int codes[3] = '{0, 2, 15};
    int n;
    wr(`OFS_IRQ_ENABLE, 32'h1);
    wr(`OFS_PERIOD, 32'h03);
    foreach (codes[i]) begin
      wr(`OFS_CONTROL, 32'h00);
      wr(`OFS_IRQ_FLAG, 32'h1);
      wr(`OFS_COUNT, 32'h00);
      wr(`OFS_CONTROL, ctl(codes[i][3:0], 1'b1, 2'b00));
      n = 0;
      do begin
        @(posedge clk_sys);
        if (period_match_pulse === 1'b1) n++;
      end while (irq !== 1'b1);
      repeat (3) begin
        @(posedge clk_sys);
        if (period_match_pulse === 1'b1) n++;
      end
      chk("postscale", codes[i] + 1, n);
    end
    wr(`OFS_CONTROL, 32'h00);
  endtask

  task automatic t_irq();
    wr(`OFS_IRQ_ENABLE, 32'h0);
    wr(`OFS_IRQ_FLAG, 32'h1);
    wr(`OFS_COUNT, 32'h00);
    wr(`OFS_CONTROL, ctl(4'h0, 1'b1, 2'b00));
    wait_pulse();
    repeat (2) @(posedge clk_sys);
    chk("masked irq", 32'h0, {31'h0, irq});
    wr(`OFS_CONTROL, 32'h00);
    rdchk("flag", `OFS_IRQ_FLAG, 32'h1);
    wr(`OFS_IRQ_ENABLE, 32'h1);
    repeat (2) @(posedge clk_sys);
    chk("irq", 32'h1, {31'h0, irq});
    wr(`OFS_IRQ_FLAG, 32'h1);
    repeat (2) @(posedge clk_sys);
    chk("cleared irq", 32'h0, {31'h0, irq});
    rdchk("flag", `OFS_IRQ_FLAG, 32'h0);
  endtask

  task automatic t_rerun_reset();
    wr(`OFS_PERIOD, 32'h40);
    wr(`OFS_COUNT, 32'h20);
    wr(`OFS_CONTROL, ctl(4'h3, 1'b1, 2'b01));
    rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    rdchk("reset count", `OFS_COUNT, 32'h00);
    rdchk("reset period", `OFS_PERIOD, 32'hff);
    rdchk("reset control", `OFS_CONTROL, 32'h00);
    rdchk("reset enable", `OFS_IRQ_ENABLE, 32'h0);
    chk("reset irq", 32'h0, {31'h0, irq});
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_regs();
    t_rate();
    t_hold();
    t_scaler_clear();
    t_post();
    t_irq();
    t_rerun_reset();
    end_sim();
  end
endmodule
